// *** sim/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// processor core side of the register bus
module core_model
    import sim_regs_pkg::*;
(
    input wire logic clk,         // system clock
    input wire logic [7:0] rdata, // read data back
    input wire logic rd_valid,    // read data strobe
    output cpu_req_t cpu          // bus request
);
    initial cpu = '0;
    // one access per call, held over exactly one sampling edge
    task automatic acc(input logic [15:0] a, input logic r,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        cpu = '{addr: a, rd: r, wr: !r, wdata: d};
        @(posedge clk);
        @(negedge clk);
        q = rd_valid ? rdata : 8'hxx;
        // released lines show the inverse, not a stale copy
        cpu = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// *** sim/test_sim_reset_break_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sim_reset_break_status_regs;
    import sim_regs_pkg::*;
    logic clk;
    logic sys_rst;
    logic ce;
    logic wait_mode;
    logic break_irq;
    logic break_active;
    logic rd_valid;
    logic bwf;
    logic allow;
    logic [3:0] arm;
    logic [3:0] step2;
    logic [3:0] grant;
    logic [7:0] rdata;
    cpu_req_t cpu;
    rst_evt_t evt;
    int errors;
    int compares;
    int cyc;
    logic [5:0] ev [7] = '{6'h20, 6'h10, 6'h08, 6'h06, 6'h01, 6'h04, 6'h21};
    logic [7:0] ex [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h00, 8'h42};

    sim_reset_break_status_regs #(.NUM_GUARD(4)) uut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .cpu(cpu), .evt(evt),
        .wait_mode(wait_mode), .break_irq(break_irq),
        .break_active(break_active), .guard_arm(arm),
        .guard_step2(step2), .rdata(rdata), .rd_valid(rd_valid),
        .break_wait_exit_flag(bwf), .clear_allow(allow),
        .guard_grant(grant)
    );
    core_model core (.clk(clk), .rdata(rdata), .rd_valid(rd_valid),
        .cpu(cpu));

    // ==========================================================
    // helpers
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] q;
        core.acc(a, 1'b1, 8'h00, q);
        check("rdata", q, e);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        core.acc(a, 1'b0, d, q);
    endtask

    task automatic pulse_brk;
        @(negedge clk);
        break_irq = 1'b1;
        @(negedge clk);
        break_irq = 1'b0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rdc(ADDR_BREAK_STATUS, 8'h00);
        rdc(ADDR_RESET_SOURCE, 8'h80);
        rdc(ADDR_BREAK_FLAG_CONTROL, 8'h00);
        rdc(ADDR_RESET_SOURCE, 8'h00);
        rdc(16'hfe02, 8'h00);
    endtask

    task automatic t_sources;
        for (int i = 0; i < 7; i++)
        begin
            @(negedge clk);
            evt = ev[i];
            @(negedge clk);
            evt = '0;
            rdc(ADDR_RESET_SOURCE, ex[i]);
        end
        // event landing on the clearing read must survive it
        fork
            rdc(ADDR_RESET_SOURCE, 8'h00);
            begin
                @(negedge clk);
                evt = 6'h10;
                @(negedge clk);
                evt = '0;
            end
        join
        rdc(ADDR_RESET_SOURCE, 8'h20);
    endtask

    task automatic t_wait;
        wait_mode = 1'b1;
        pulse_brk();
        check("bw", {7'h00, bwf}, 8'h01);
        rdc(ADDR_BREAK_STATUS, 8'h02);
        wr(ADDR_BREAK_STATUS, 8'hff);
        rdc(ADDR_BREAK_STATUS, 8'h02);
        wr(ADDR_BREAK_STATUS, 8'h00);
        rdc(ADDR_BREAK_STATUS, 8'h00);
        pulse_brk();
        @(negedge clk);
        evt = 6'h20;
        @(negedge clk);
        evt = '0;
        rdc(ADDR_BREAK_STATUS, 8'h00);
        rdc(ADDR_RESET_SOURCE, 8'h40);
        wait_mode = 1'b0;
        pulse_brk();
        rdc(ADDR_BREAK_STATUS, 8'h00);
    endtask

    task automatic t_ctrl;
        wr(ADDR_BREAK_FLAG_CONTROL, 8'hff);
        rdc(ADDR_BREAK_FLAG_CONTROL, 8'h80);
        // a write with the clock enable low must not land
        ce = 1'b0;
        wr(ADDR_BREAK_FLAG_CONTROL, 8'h00);
        ce = 1'b1;
        rdc(ADDR_BREAK_FLAG_CONTROL, 8'h80);
        wr(ADDR_RESET_SOURCE, 8'hff);
        rdc(ADDR_RESET_SOURCE, 8'h00);
    endtask

    task automatic t_guard(input logic ba, en, doarm, input logic [3:0] e);
        wr(ADDR_BREAK_FLAG_CONTROL, {en, 7'h00});
        @(negedge clk);
        break_active = ba;
        arm = {3'b000, doarm};
        @(negedge clk);
        arm = '0;
        step2 = 4'h1;
        @(negedge clk);
        step2 = '0;
        check("grant", {4'h0, grant}, {4'h0, e});
        check("allow", {7'h00, allow}, {7'h00, !ba | en});
    endtask

    // ==========================================================
    // clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            end_sim();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        evt = '0;
        wait_mode = 1'b0;
        break_irq = 1'b0;
        break_active = 1'b0;
        arm = '0;
        step2 = '0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_sources();
        t_wait();
        t_ctrl();
        t_guard(1'b1, 1'b0, 1'b1, 4'h0);
        t_guard(1'b0, 1'b0, 1'b0, 4'h1);
        t_guard(1'b1, 1'b1, 1'b1, 4'h1);
        end_sim();
    end
endmodule
`default_nettype wire

// *** verilog/flag_clear_guard.sv ***
`timescale 1ns/1ps
`default_nettype none
module flag_clear_guard
    import sim_regs_pkg::*;
#(
    parameter int NUM_FLAGS = 4
)
(
    input wire logic clk,                      // system clock
    input wire logic sys_rst,                  // async reset, high
    input wire logic ce,                       // clock enable
    input wire logic allow,                    // clearing permitted now
    input wire logic [NUM_FLAGS-1:0] arm,      // first step of clear
    input wire logic [NUM_FLAGS-1:0] step2,    // second step of clear
    output logic [NUM_FLAGS-1:0] grant         // clear strobe to flag
);
    // ==========================================================
    // per-flag two-step tracking
    logic [NUM_FLAGS-1:0] arm_reg;
    logic [NUM_FLAGS-1:0] arm_next;
    logic [NUM_FLAGS-1:0] grant_next;

    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g = g + 1)
        begin : g_flag
            // blocked second step leaves the first step pending
            assign grant_next[g] = step2[g] & arm_reg[g] & allow;
            // a fresh first step beats the consume
            assign arm_next[g] = arm[g] ? 1'b1 :
                                 (grant_next[g] ? 1'b0 : arm_reg[g]);
        end
    endgenerate

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            arm_reg <= '0;
            grant <= '0;
        end
        else if (ce)
        begin
            arm_reg <= arm_next;
            grant <= grant_next;
        end
    end

    // ==========================================================
    // checks
    property p_step_kept;
        @(posedge clk) disable iff (sys_rst)
        (ce && !allow && (step2 & arm_reg) != '0) |=>
            ((arm_reg & $past(step2 & arm_reg)) == $past(step2 & arm_reg))
            && ((grant & $past(step2)) == '0);
    endproperty
    a_step_kept: assert property (p_step_kept)
        else $error("blocked second step lost its pending state");

    cover property (@(posedge clk) disable iff (sys_rst)
        ce && !allow && (step2 & arm_reg) != '0 ##[1:20] grant != '0);
endmodule
`default_nettype wire

// *** verilog/sim_regs_pkg.sv ***
`default_nettype none
package sim_regs_pkg;
    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ==========================================================
    // register addresses
    localparam logic [15:0] ADDR_BREAK_STATUS = 16'hfe00;
    localparam logic [15:0] ADDR_RESET_SOURCE = 16'hfe01;
    localparam logic [15:0] ADDR_BREAK_FLAG_CONTROL = 16'hfe03;

    // ==========================================================
    // field positions
    localparam int BW_BIT = 1;
    localparam int BREAK_CLEAR_ENABLE_BIT = 7;
    localparam int RS_POR_BIT = 7;
    localparam int RS_PIN_BIT = 6;
    localparam int RS_WDOG_BIT = 5;
    localparam int RS_BADOP_BIT = 4;
    localparam int RS_BADFETCH_BIT = 3;
    localparam int RS_UV_BIT = 1;

    // ==========================================================
    // implemented-bit masks and reset values
    localparam logic [7:0] BREAK_STATUS_MASK = 8'h02;
    localparam logic [7:0] RESET_SOURCE_MASK = 8'hfa;
    localparam logic [7:0] BREAK_FLAG_CONTROL_MASK = 8'h80;
    localparam logic [7:0] BREAK_STATUS_RST = 8'h00;
    localparam logic [7:0] RESET_SOURCE_POR = 8'h80;
    localparam logic [7:0] BREAK_FLAG_CONTROL_RST = 8'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic pin;
        logic wdog;
        logic bad_op;
        logic bad_fetch;
        logic fetch_cycle;
        logic uv;
    } rst_evt_t;
endpackage
`default_nettype wire

// *** verilog/sim_reset_break_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - Decode the three registers at fixed addresses FE00, FE01 and FE03.
// - Set break-wait-exit flag when a break ends WAIT; else it stays clear.
// - Writing 0 clears break-wait-exit flag; any reset clears it too.
// - Break-wait-exit flag stays readable during the break service routine.
// - Six reset-source flags; reading the register clears all of them.
// - Power-on reset sets power-on flag and clears all other source flags.
// - External reset pin sets its flag; power-on or read clears it.
// - Watchdog reset sets its flag; power-on or read clears it.
// - Illegal opcode reset sets its flag; power-on or read clears it.
// - Bad-fetch flag set only by opcode fetches from illegal addresses.
// - Undervoltage reset sets its flag; power-on or read clears it.
// - In break, peripheral flag clears allowed only when enable bit is 1.
// - Break-clear-enable is a plain read/write control bit.
// - Flags cleared in break with clearing enabled stay cleared afterwards.
// - Two-step clears blocked in break; later second step clears normally.
module sim_reset_break_status_regs
    import sim_regs_pkg::*;
#(
    parameter int NUM_GUARD = 4
)
(
    input wire logic clk,                        // 100 MHz system clock
    input wire logic sys_rst,                    // async power-on reset
    input wire logic ce,                         // clock enable
    input wire cpu_req_t cpu,                    // cpu register access
    input wire rst_evt_t evt,                    // internal reset events
    input wire logic wait_mode,                  // core is in WAIT
    input wire logic break_irq,                  // break interrupt pulse
    input wire logic break_active,               // core in break state
    input wire logic [NUM_GUARD-1:0] guard_arm,  // peripheral clear step 1
    input wire logic [NUM_GUARD-1:0] guard_step2, // peripheral clear step 2
    output logic [7:0] rdata,                    // read data
    output logic rd_valid,                       // read data valid
    output logic break_wait_exit_flag,           // flag mirror
    output logic clear_allow,                    // peripherals may clear
    output logic [NUM_GUARD-1:0] guard_grant     // clear strobes
);
    // ==========================================================
    // address decode
    logic [7:0] break_status_reg;
    logic [7:0] reset_source_reg;
    logic [7:0] break_flag_control_reg;
    logic clear_allow_reg;

    wire sel_bs = (cpu.addr == ADDR_BREAK_STATUS);
    wire sel_rs = (cpu.addr == ADDR_RESET_SOURCE);
    wire sel_bfc = (cpu.addr == ADDR_BREAK_FLAG_CONTROL);
    wire wr_bs = ce & cpu.wr & sel_bs;
    wire wr_bfc = ce & cpu.wr & sel_bfc;
    wire rd_rs = ce & cpu.rd & sel_rs;

    // ==========================================================
    // break-wait-exit flag
    wire any_int_rst = evt.pin | evt.wdog | evt.bad_op |
                       (evt.bad_fetch & evt.fetch_cycle) | evt.uv;
    wire bw_set = break_irq & wait_mode;
    wire bw_wr_clr = wr_bs & ~cpu.wdata[BW_BIT];
    // set beats both clears so a break landing on the write is kept
    wire bw_next = bw_set ? 1'b1 :
                   ((any_int_rst | bw_wr_clr) ? 1'b0 :
                    break_status_reg[BW_BIT]);
    wire [7:0] bs_next = {6'b00_0000, bw_next, 1'b0} & BREAK_STATUS_MASK;

    // ==========================================================
    // reset source flags
    wire [7:0] rs_set;
    assign rs_set[RS_POR_BIT] = 1'b0;
    assign rs_set[RS_PIN_BIT] = evt.pin;
    assign rs_set[RS_WDOG_BIT] = evt.wdog;
    assign rs_set[RS_BADOP_BIT] = evt.bad_op;
    // data accesses to bad addresses must not mark the fetch source
    assign rs_set[RS_BADFETCH_BIT] = evt.bad_fetch
                                     & evt.fetch_cycle;
    assign rs_set[2] = 1'b0;
    assign rs_set[RS_UV_BIT] = evt.uv;
    assign rs_set[0] = 1'b0;
    // a reset arriving with the read survives it
    wire [7:0] rs_next = ((rd_rs ? DATA_ZERO : reset_source_reg) | rs_set)
                         & RESET_SOURCE_MASK;

    // ==========================================================
    // break flag control and clear permission
    wire [7:0] bfc_wval = cpu.wdata & BREAK_FLAG_CONTROL_MASK;
    wire [7:0] bfc_next = wr_bfc ? bfc_wval
                                 : break_flag_control_reg;
    wire break_clear_enable = break_flag_control_reg[BREAK_CLEAR_ENABLE_BIT];
    wire allow_now = ~break_active | break_clear_enable;

    // ==========================================================
    // read mux; unmapped addresses answer zero
    wire [7:0] rd_mux = sel_bs ? break_status_reg :
                        (sel_rs ? reset_source_reg :
                         (sel_bfc ? break_flag_control_reg : DATA_ZERO));
    wire [7:0] rdata_next = cpu.rd ? rd_mux : rdata;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            break_status_reg <= BREAK_STATUS_RST;
            reset_source_reg <= RESET_SOURCE_POR;
            break_flag_control_reg <= BREAK_FLAG_CONTROL_RST;
            clear_allow_reg <= 1'b1;
            rdata <= DATA_ZERO;
            rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            break_status_reg <= bs_next;
            reset_source_reg <= rs_next;
            break_flag_control_reg <= bfc_next;
            clear_allow_reg <= allow_now;
            rdata <= rdata_next;
            rd_valid <= cpu.rd;
        end
    end

    assign break_wait_exit_flag = break_status_reg[BW_BIT];
    assign clear_allow = clear_allow_reg;

    // ==========================================================
    // peripheral clear gating; a granted clear is final in the
    // peripheral, so nothing here restores it after break
    flag_clear_guard #(
        .NUM_FLAGS(NUM_GUARD)
    ) u_guard (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .allow(allow_now),
        .arm(guard_arm),
        .step2(guard_step2),
        .grant(guard_grant)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic first_reg;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            first_reg <= 1'b1;
        else
            first_reg <= 1'b0;
    end

    property p_por_value;
        first_reg |-> (reset_source_reg == RESET_SOURCE_POR)
            && !break_wait_exit_flag;
    endproperty
    a_por_value: assert property (p_por_value)
        else $error("power-on values wrong");

    property p_bw_set;
        ce && break_irq && wait_mode |=> break_wait_exit_flag ##1
            (break_wait_exit_flag || !ce || $past(bw_wr_clr || any_int_rst));
    endproperty
    a_bw_set: assert property (p_bw_set)
        else $error("break wait exit not recorded");

    property p_bw_only_break;
        ce && !break_wait_exit_flag && !(break_irq && wait_mode)
            |=> !break_wait_exit_flag;
    endproperty
    a_bw_only_break: assert property (p_bw_only_break)
        else $error("break wait flag set without cause");

    property p_bw_clear;
        ce && (bw_wr_clr || any_int_rst) && !bw_set |=> !break_wait_exit_flag;
    endproperty
    a_bw_clear: assert property (p_bw_clear)
        else $error("break wait flag not cleared");

    property p_bs_read;
        ce && cpu.rd && sel_bs |=>
            rd_valid && rdata == $past(break_status_reg) &&
            (rdata & ~BREAK_STATUS_MASK) == DATA_ZERO;
    endproperty
    a_bs_read: assert property (p_bs_read)
        else $error("break status read wrong");

    property p_rs_read_clear;
        rd_rs && rs_set == DATA_ZERO |=>
            rdata == $past(reset_source_reg) && reset_source_reg == DATA_ZERO;
    endproperty
    a_rs_read_clear: assert property (p_rs_read_clear)
        else $error("reset source not cleared by read");

    property p_rs_sources;
        ce && (evt.pin || evt.wdog || evt.bad_op || evt.uv) |=>
            (!$past(evt.pin) || reset_source_reg[RS_PIN_BIT]) &&
            (!$past(evt.wdog) || reset_source_reg[RS_WDOG_BIT]) &&
            (!$past(evt.bad_op) || reset_source_reg[RS_BADOP_BIT]) &&
            (!$past(evt.uv) || reset_source_reg[RS_UV_BIT]);
    endproperty
    a_rs_sources: assert property (p_rs_sources)
        else $error("reset source flag missed");

    property p_fetch_only;
        ce && evt.bad_fetch && !evt.fetch_cycle && !rd_rs |=>
            $stable(reset_source_reg[RS_BADFETCH_BIT]);
    endproperty
    a_fetch_only: assert property (p_fetch_only)
        else $error("data access set bad fetch flag");

    property p_protect;
        ce && break_active && !break_clear_enable |=> guard_grant == '0 && !clear_allow;
    endproperty
    a_protect: assert property (p_protect)
        else $error("flag cleared while protected");

    property p_bfc_rw;
        wr_bfc |=> break_flag_control_reg ==
            ($past(cpu.wdata) & BREAK_FLAG_CONTROL_MASK);
    endproperty
    a_bfc_rw: assert property (p_bfc_rw)
        else $error("break flag control write lost");

    property p_unmapped;
        ce && cpu.rd && !sel_bs && !sel_rs && !sel_bfc |=> rdata == DATA_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    c_bw: cover property (ce && bw_set ##[1:50] rd_valid && rdata[BW_BIT]);
    c_rs_read: cover property (rd_rs && reset_source_reg != DATA_ZERO);
    c_break_clear: cover property (break_active && break_clear_enable && guard_grant != '0);
    c_protected: cover property (break_active && !break_clear_enable && guard_step2 != '0);
endmodule
`default_nettype wire
